// *** rtl/fee_consts.svh ***
`ifndef FEE_CONSTS_SVH
`define FEE_CONSTS_SVH

// control word width and reset value
`define FEE_CTRL_W        16
`define FEE_CTRL_RESET    16'h0000
// bits that hold storage; the rest read as zero
`define FEE_CTRL_MASK     16'h3F3F

// bit positions of the control word
`define FEE_B_VCOBUF      13
`define FEE_B_VCO         12
`define FEE_B_OPEN_LOOP   11
`define FEE_B_CLK_GATE    10
`define FEE_B_LOCK_START  9
`define FEE_B_SYN_BIAS    8
`define FEE_B_MPA         5
`define FEE_B_TXBUF       4
`define FEE_B_MIXQ        3
`define FEE_B_MIXI        2
`define FEE_B_LNA         1
`define FEE_B_RXBUF       0

`endif

// *** rtl/fee_pkg.sv ***
`default_nettype none
package fee_pkg;

	// enable lines to the analog blocks and synthesizer
	typedef struct packed {
		logic vcobuf;
		logic vco;
		logic mpa;
		logic txbuf;
		logic mixq;
		logic mixi;
		logic lna;
		logic rxbuf;
		logic syn_bias;
		logic syn_clk;
		logic lock_start;
		logic open_loop;
	} fee_en_t;

	// synthesizer loop tracking
	typedef enum logic [1:0] {
		FEE_CLOSED  = 2'b00,
		FEE_LOCKING = 2'b01,
		FEE_OPEN    = 2'b10
	} fee_loop_t;

endpackage

`default_nettype wire

// *** rtl/fee_enable_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fee_consts.svh"

module fee_enable_reg (
	input  wire logic                   CLK_SYS,
	input  wire logic                   RST,
	input  wire logic                   WR_STB,
	input  wire logic [`FEE_CTRL_W-1:0] WR_DATA,
	input  wire logic                   LOCK_DET,
	output logic      [`FEE_CTRL_W-1:0] RD_DATA,
	output fee_pkg::fee_en_t            EN_OUT
);

	logic [`FEE_CTRL_W-1:0] ctrl_q;
	logic [`FEE_CTRL_W-1:0] ctrl_d;
	fee_pkg::fee_en_t       en_q;
	fee_pkg::fee_en_t       en_d;
	fee_pkg::fee_loop_t     loop_q;
	fee_pkg::fee_loop_t     loop_d;

	// map the control word onto the enable lines
	function automatic fee_pkg::fee_en_t fee_decode(input logic [`FEE_CTRL_W-1:0] w,
			input fee_pkg::fee_loop_t lp);
		fee_pkg::fee_en_t e;
		e.vcobuf     = w[`FEE_B_VCOBUF];
		e.vco        = w[`FEE_B_VCO];
		e.mpa        = w[`FEE_B_MPA];
		e.txbuf      = w[`FEE_B_TXBUF];
		e.mixq       = w[`FEE_B_MIXQ];
		e.mixi       = w[`FEE_B_MIXI];
		e.lna        = w[`FEE_B_LNA];
		e.rxbuf      = w[`FEE_B_RXBUF];
		e.syn_bias   = w[`FEE_B_SYN_BIAS];
		e.syn_clk    = w[`FEE_B_CLK_GATE];
		e.lock_start = w[`FEE_B_LOCK_START];
		e.open_loop  = (lp == fee_pkg::FEE_OPEN);
		return e;
	endfunction

	// control word update at the end of a serial access
	always_comb begin
		ctrl_d = ctrl_q;
		if (WR_STB) begin
			ctrl_d = WR_DATA & `FEE_CTRL_MASK;
		end
	end

	// loop tracking: closed, locking, opened after lock
	always_comb begin
		loop_d = loop_q;
		// locking only while lock-start is set
		if (!ctrl_d[`FEE_B_LOCK_START] || !ctrl_d[`FEE_B_SYN_BIAS]) begin
			loop_d = fee_pkg::FEE_CLOSED;
		end else begin
			case (loop_q)
				fee_pkg::FEE_CLOSED: begin
					loop_d = fee_pkg::FEE_LOCKING;
				end
				// open loop once lock detect seen while the open-loop bit is set
				fee_pkg::FEE_LOCKING: begin
					if (LOCK_DET && ctrl_d[`FEE_B_OPEN_LOOP]) begin
						loop_d = fee_pkg::FEE_OPEN;
					end
				end
				// bit cleared returns to locking
				fee_pkg::FEE_OPEN: begin
					if (!ctrl_d[`FEE_B_OPEN_LOOP]) begin
						loop_d = fee_pkg::FEE_LOCKING;
					end
				end
				default: begin
					loop_d = fee_pkg::FEE_CLOSED;
				end
			endcase
		end
	end

	// enables follow the new word together
	always_comb begin
		en_d = fee_decode(ctrl_d, loop_d);
	end

	// registers
	// reset to zero
	always_ff @(posedge CLK_SYS or posedge RST) begin
		if (RST) begin
			ctrl_q <= `FEE_CTRL_RESET;
			en_q   <= '0;
			loop_q <= fee_pkg::FEE_CLOSED;
		end else begin
			ctrl_q <= ctrl_d;
			en_q   <= en_d;
			loop_q <= loop_d;
		end
	end

	assign RD_DATA = ctrl_q;
	assign EN_OUT  = en_q;

	// checks
	property p_reserved_zero;
		@(posedge CLK_SYS) disable iff (RST)
		(RD_DATA & ~`FEE_CTRL_MASK) == 16'h0000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

	property p_write_read;
		@(posedge CLK_SYS) disable iff (RST)
		WR_STB |=> RD_DATA == ($past(WR_DATA) & `FEE_CTRL_MASK);
	endproperty
	a_write_read: assert property (p_write_read) else $error("read differs from write");

	property p_hold;
		@(posedge CLK_SYS) disable iff (RST)
		!WR_STB |=> $stable(RD_DATA);
	endproperty
	a_hold: assert property (p_hold) else $error("word changed without write");

	property p_blocks;
		@(posedge CLK_SYS) disable iff (RST)
		WR_STB |=> {EN_OUT.vcobuf, EN_OUT.vco, EN_OUT.mpa, EN_OUT.txbuf, EN_OUT.mixq,
			EN_OUT.mixi, EN_OUT.lna, EN_OUT.rxbuf, EN_OUT.syn_bias}
			== {$past(WR_DATA[`FEE_B_VCOBUF:`FEE_B_VCO]), $past(WR_DATA[`FEE_B_MPA:`FEE_B_RXBUF]),
			$past(WR_DATA[`FEE_B_SYN_BIAS])};
	endproperty
	a_blocks: assert property (p_blocks) else $error("block enable mismatch");

	property p_clk_gate;
		@(posedge CLK_SYS) disable iff (RST)
		EN_OUT.syn_clk == RD_DATA[`FEE_B_CLK_GATE];
	endproperty
	a_clk_gate: assert property (p_clk_gate) else $error("clock gate mismatch");

	property p_lock_start;
		@(posedge CLK_SYS) disable iff (RST)
		!RD_DATA[`FEE_B_LOCK_START] |-> !EN_OUT.open_loop && EN_OUT.lock_start == 1'b0;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("lock start mismatch");

	sequence s_locking;
		RD_DATA[`FEE_B_LOCK_START] && RD_DATA[`FEE_B_SYN_BIAS] && RD_DATA[`FEE_B_OPEN_LOOP] && !WR_STB;
	endsequence

	property p_open_after_lock;
		@(posedge CLK_SYS) disable iff (RST)
		s_locking ##1 (s_locking and LOCK_DET) |=> EN_OUT.open_loop;
	endproperty
	a_open_after_lock: assert property (p_open_after_lock) else $error("loop not opened after lock");

	property p_closed;
		@(posedge CLK_SYS) disable iff (RST)
		!RD_DATA[`FEE_B_OPEN_LOOP] |-> !EN_OUT.open_loop;
	endproperty
	a_closed: assert property (p_closed) else $error("loop open while bit clear");

	// block enables mirror the stored word at every edge
	property p_rf_mirror;
		@(posedge CLK_SYS) disable iff (RST)
		{EN_OUT.vcobuf, EN_OUT.vco, EN_OUT.mpa, EN_OUT.txbuf,
			EN_OUT.mixq, EN_OUT.mixi, EN_OUT.lna, EN_OUT.rxbuf}
			== {RD_DATA[`FEE_B_VCOBUF:`FEE_B_VCO], RD_DATA[`FEE_B_MPA:`FEE_B_RXBUF]};
	endproperty
	a_rf_mirror: assert property (p_rf_mirror) else $error("block enables differ from word");

	// synthesizer bias follows its bit
	property p_bias_mirror;
		@(posedge CLK_SYS) disable iff (RST)
		EN_OUT.syn_bias == RD_DATA[`FEE_B_SYN_BIAS];
	endproperty
	a_bias_mirror: assert property (p_bias_mirror) else $error("bias enable differs from word");

	// lock start follows its bit
	property p_lock_mirror;
		@(posedge CLK_SYS) disable iff (RST)
		EN_OUT.lock_start == RD_DATA[`FEE_B_LOCK_START];
	endproperty
	a_lock_mirror: assert property (p_lock_mirror) else $error("lock start differs from word");

	// loop opens only after lock detect was seen
	property p_open_needs_lock;
		@(posedge CLK_SYS) disable iff (RST)
		$rose(EN_OUT.open_loop) |-> $past(LOCK_DET);
	endproperty
	a_open_needs_lock: assert property (p_open_needs_lock) else $error("loop opened without lock");

	// open loop kept while its bits stay set, even if lock detect falls
	sequence s_open_kept;
		EN_OUT.open_loop && RD_DATA[`FEE_B_OPEN_LOOP] && RD_DATA[`FEE_B_LOCK_START]
			&& RD_DATA[`FEE_B_SYN_BIAS] && !WR_STB;
	endsequence

	property p_open_hold;
		@(posedge CLK_SYS) disable iff (RST)
		s_open_kept |=> EN_OUT.open_loop;
	endproperty
	a_open_hold: assert property (p_open_hold) else $error("open loop dropped while bits kept");

	// open loop needs locking started and bias on
	property p_open_needs_active;
		@(posedge CLK_SYS) disable iff (RST)
		EN_OUT.open_loop |-> EN_OUT.lock_start && EN_OUT.syn_bias;
	endproperty
	a_open_needs_active: assert property (p_open_needs_active) else $error("loop open while inactive");

	// bias off keeps the loop from opening
	property p_bias_off_closed;
		@(posedge CLK_SYS) disable iff (RST)
		!RD_DATA[`FEE_B_SYN_BIAS] |-> !EN_OUT.open_loop;
	endproperty
	a_bias_off_closed: assert property (p_bias_off_closed) else $error("loop open while bias off");

	// synthesizer controls take the written word in one step
	property p_write_together;
		@(posedge CLK_SYS) disable iff (RST)
		WR_STB |=> EN_OUT.syn_clk == $past(WR_DATA[`FEE_B_CLK_GATE])
			&& EN_OUT.lock_start == $past(WR_DATA[`FEE_B_LOCK_START]);
	endproperty
	a_write_together: assert property (p_write_together) else $error("synthesizer controls lag write");

	// writing the open-loop bit clear closes the loop next cycle
	property p_clear_closes;
		@(posedge CLK_SYS) disable iff (RST)
		WR_STB && !WR_DATA[`FEE_B_OPEN_LOOP] |=> !EN_OUT.open_loop;
	endproperty
	a_clear_closes: assert property (p_clear_closes) else $error("loop still open after clear");

endmodule

`default_nettype wire

// *** testbench/fee_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fee_host_model (
	input  wire logic        clk,
	output var  logic        wr_stb,
	output var  logic [15:0] wr_data
);
	// idle bus
	initial begin
		wr_stb = 1'b0;
		wr_data = 16'h0000;
	end
	task automatic write(input logic [15:0] v);
		@(negedge clk);
		wr_stb = 1'b1;
		wr_data = v;
		@(negedge clk);
		wr_stb = 1'b0;
		wr_data = ~v;
	endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fee_consts.svh"
module tb_top;
	logic             clk_sys = 1'b0;
	logic             rst = 1'b1;
	logic             lock_det = 1'b0;
	logic             wr_stb;
	logic [15:0]      wr_data;
	logic [15:0]      rd_data;
	fee_pkg::fee_en_t en_out;
	int               n_mismatch = 0;
	int               tests_run = 0;
	logic [15:0]      v;
	// 100 MHz clock
	always #5 clk_sys = ~clk_sys;
	fee_host_model i_fee_host_model (.clk(clk_sys), .wr_stb(wr_stb), .wr_data(wr_data));
	fee_enable_reg i_fee_enable_reg (.CLK_SYS(clk_sys), .RST(rst), .WR_STB(wr_stb), .WR_DATA(wr_data),
		.LOCK_DET(lock_det), .RD_DATA(rd_data), .EN_OUT(en_out));
	// expected read word and enables
	function automatic logic [27:0] exp_of(input logic [15:0] e, input logic ol);
		return {e & `FEE_CTRL_MASK, e[13], e[12], e[5:0], e[8], e[10], e[9], ol};
	endfunction
	task automatic chk(input logic [15:0] e, input logic ol);
		tests_run++;
		if ({rd_data, en_out} !== exp_of(e, ol)) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, {rd_data, en_out}, exp_of(e, ol));
		end
	endtask
	task automatic wr_chk(input logic [15:0] e, input logic ol);
		i_fee_host_model.write(e);
		chk(e, ol);
	endtask
	task automatic tally_and_finish;
		$display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#20000;
		n_mismatch++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		v = 16'($urandom(32'hA609));
		repeat (6) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		chk(16'h0000, 1'b0);
		$display("test reset done");
		wr_chk(16'h373F, 1'b0);
		lock_det = 1'b1;
		repeat (3) @(negedge clk_sys);
		chk(16'h373F, 1'b0);
		$display("test cw done");
		wr_chk(16'h0900, 1'b0);
		repeat (3) @(negedge clk_sys);
		chk(16'h0900, 1'b0);
		lock_det = 1'b0;
		$display("test pulsed done");
		wr_chk(16'h0B00, 1'b0);
		repeat (3) @(negedge clk_sys);
		chk(16'h0B00, 1'b0);
		lock_det = 1'b1;
		repeat (2) @(negedge clk_sys);
		lock_det = 1'b0;
		chk(16'h0B00, 1'b1);
		@(negedge clk_sys);
		chk(16'h0B00, 1'b1);
		i_fee_host_model.write(16'h0300);
		@(negedge clk_sys);
		chk(16'h0300, 1'b0);
		$display("test loop done");
		wr_chk(16'hFFFF, 1'b0);
		wr_chk(16'h0000, 1'b0);
		repeat (40) begin
			v = 16'($urandom);
			wr_chk(v, 1'b0);
		end
		$display("test random done");
		@(negedge clk_sys);
		rst = 1'b1;
		@(negedge clk_sys);
		chk(16'h0000, 1'b0);
		rst = 1'b0;
		wr_chk(16'h0B00, 1'b0);
		$display("test mid reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
